// file: logic/map_access_defines.vh
// constants for the tcp boolean mapping point request handler
// assumes byte-wide request and response streams framed by a start strobe
// Summary of operation
// R01: frames open with a two-byte transaction tag pairing requests and replies.
// R02: protocol tag follows and must be zero in requests and replies.
// R03: two-byte length counts following bytes; read or single write carries six.
// R04: unit address must equal configured device address, range 1 to 247.
// R05: function 01 reads boolean points from start address and point count.
// R06: read start address lies within 0x40 to 0x7f.
// R07: read reply gives byte count then that many packed data bytes.
// R08: two-byte read reply carries length five.
// R09: start address lands in bit 0 of first byte, ascending onward.
// R10: bits past the requested count in the last byte are zero.
// R11: function 05 writes one point from point address and value.
// R12: write value ff00 sets the point, 0000 clears it.
// R13: single write address lies within 0x40 to 0x7f.
// R14: a modified point is forwarded to its downstream ethernet slave.
// R15: good single write is echoed with length six.
// R16: replies copy tag and unit; foreign unit or protocol is ignored.
// R17: out-of-window ranges or bad write values leave points unchanged.
`ifndef MAP_ACCESS_DEFINES_VH
`define MAP_ACCESS_DEFINES_VH
`define HDR_BYTES 8'h0c
`define PROTO_ZERO 16'h0000
`define REQ_LEN 16'h0006
`define FC_READ 8'h01
`define FC_WRITE 8'h05
`define MAP_LO 16'h0040
`define MAP_HI 16'h007f
`define MAP_DEPTH 7'h40
`define VAL_ONE 16'hff00
`define VAL_ZERO 16'h0000
`define UNIT_MIN 8'h01
`define UNIT_MAX 8'hf7
`define RD_LEN_BASE 16'h0003
`define WR_REPLY_BYTES 8'h0c
`define RD_FIXED_BYTES 8'h09
`endif

// file: logic/point_bank.v
// bank of 64 boolean mapping points with registered byte read
// assumes one clock; write port takes effect on the next edge
`timescale 1ns/1ps
module point_bank
(
   input wire core_clk_in, // system clock
   input wire nrst_in, // async reset, active low
   input wire wr_en_in, // write one point
   input wire [5:0] wr_idx_in, // point index
   input wire wr_val_in, // new point value
   input wire [5:0] rd_idx_in, // first point of byte
   input wire [3:0] rd_cnt_in, // valid bits in byte, 1..8
   output reg [7:0] rd_byte_out // packed byte, registered
);
   reg [63:0] pts_q;
   wire [7:0] pick;
   // ============================================================
   // storage
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         pts_q <= 64'h0000_0000_0000_0000;
      else if (wr_en_in)
         pts_q[wr_idx_in] <= wr_val_in;
   end
   // ============================================================
   // packing: bit k is point rd_idx+k, zero past count or window end
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1)
      begin : g_pack
         localparam [6:0] OFS = k;
         wire [6:0] idx = {1'b0, rd_idx_in} + OFS;
         assign pick[k] = (k < rd_cnt_in) && !idx[6] && pts_q[idx[5:0]]; // [R09] [R10]
      end
   endgenerate
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         rd_byte_out <= 8'h00;
      else
         rd_byte_out <= pick;
   end
endmodule

// file: logic/frame_rx.v
// collects the twelve bytes of a request frame into fields
// assumes a start pulse at the first byte of each frame
`timescale 1ns/1ps
`include "map_access_defines.vh"
module frame_rx
(
   input wire core_clk_in, // system clock
   input wire nrst_in, // async reset, active low
   input wire sof_in, // first byte of frame
   input wire vld_in, // byte valid
   input wire [7:0] byte_in, // request byte
   output reg done_out, // frame complete pulse
   output reg [95:0] frame_out // bytes, first in top
);
   reg [7:0] cnt_q;
   // ============================================================
   // shift in bytes; a new start discards a partial frame
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cnt_q <= 8'h00;
         done_out <= 1'b0;
         frame_out <= 96'h0;
      end
      else
      begin
         done_out <= 1'b0;
         if (vld_in)
         begin
            frame_out <= {frame_out[87:0], byte_in};
            if (sof_in)
               cnt_q <= 8'h01;
            else if (cnt_q != 8'h00 && cnt_q < `HDR_BYTES)
               cnt_q <= cnt_q + 8'h01;
            if ((sof_in ? 8'h01 : cnt_q + 8'h01) == `HDR_BYTES)
            begin
               done_out <= 1'b1;
               cnt_q <= 8'h00;
            end
         end
      end
   end
endmodule

// file: logic/tcp_boolean_map_access.v
// request handler for boolean mapping points over tcp-framed modbus
// assumes request bytes arrive with a frame start flag and replies are
// taken one byte per cycle while tx_rdy_in is high
`timescale 1ns/1ps
`include "map_access_defines.vh"
module tcp_boolean_map_access
(
   input wire core_clk_in, // 10 MHz clock
   input wire nrst_in, // async reset, active low
   input wire [7:0] unit_addr_in, // configured device address
   input wire rx_sof_in, // first request byte
   input wire rx_vld_in, // request byte valid
   input wire [7:0] rx_byte_in, // request byte
   input wire tx_rdy_in, // reply sink ready
   input wire fwd_rdy_in, // downstream forwarder ready
   output reg tx_vld_out, // reply byte valid
   output reg tx_sof_out, // first reply byte
   output reg tx_eof_out, // last reply byte
   output reg [7:0] tx_byte_out, // reply byte
   output reg fwd_vld_out, // downstream write request
   output reg [5:0] fwd_idx_out, // point index to forward
   output reg fwd_val_out, // value to forward
   output reg busy_out // request in service
);
   localparam ST_IDLE = 2'd0;
   localparam ST_FETCH = 2'd1;
   localparam ST_SEND = 2'd2;
   localparam ST_FWD = 2'd3;
   wire done;
   wire [95:0] fr;
   wire [7:0] pk_byte;
   reg [1:0] st_q;
   reg [95:0] req_q;
   reg [7:0] pos_q;
   reg [7:0] last_q;
   reg [5:0] rd_idx_q;
   reg [3:0] rd_cnt_q;
   reg [7:0] data_q [0:7];
   reg [2:0] fill_q;
   reg wr_en;
   reg [7:0] tb;
   integer i;
   // ============================================================
   // frame field views
   wire [15:0] f_proto = fr[79:64];
   wire [15:0] f_len = fr[63:48];
   wire [7:0] f_unit = fr[47:40];
   wire [7:0] f_fc = fr[39:32];
   wire [15:0] f_addr = fr[31:16];
   wire [15:0] f_arg = fr[15:0];
   wire [16:0] f_end = {1'b0, f_addr} + {1'b0, f_arg} - 17'h0_0001;
   // unit, protocol and length must match or the frame is dropped
   wire hdr_ok = (f_proto == `PROTO_ZERO) && (f_len == `REQ_LEN) // [R02] [R03]
      && (f_unit == unit_addr_in) && (f_unit >= `UNIT_MIN) && (f_unit <= `UNIT_MAX); // [R04] [R16]
   wire in_win = (f_addr >= `MAP_LO) && (f_addr <= `MAP_HI); // [R06] [R13]
   // reads ending past the window are dropped so the reply never overruns data_q
   wire rd_ok = (f_fc == `FC_READ) && in_win && (f_arg != 16'h0000)
      && (f_end <= {1'b0, `MAP_HI}); // [R05] [R17]
   wire wr_ok = (f_fc == `FC_WRITE) && in_win
      && ((f_arg == `VAL_ONE) || (f_arg == `VAL_ZERO)); // [R11] [R12] [R17]
   wire [15:0] rd_bytes = (f_arg + 16'h0007) >> 3;
   // reply length field; the window keeps it inside the low byte
   wire [15:0] rep_len = (req_q[39:32] == `FC_READ) ? (`RD_LEN_BASE + ((req_q[15:0] + 16'h0007) >> 3)) // [R08]
      : `REQ_LEN; // [R15]
   // ============================================================
   // request assembly
   frame_rx u_rx
   (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .sof_in(rx_sof_in),
      .vld_in(rx_vld_in),
      .byte_in(rx_byte_in),
      .done_out(done),
      .frame_out(fr)
   );
   // ============================================================
   // point storage; written only by a validated single write
   always @*
   begin
      wr_en = done && hdr_ok && wr_ok && (st_q == ST_IDLE); // [R17]
   end
   point_bank u_bank
   (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .wr_en_in(wr_en),
      .wr_idx_in(f_addr[5:0]),
      .wr_val_in(f_arg == `VAL_ONE), // [R12]
      .rd_idx_in(rd_idx_q),
      .rd_cnt_in(rd_cnt_q),
      .rd_byte_out(pk_byte)
   );
   // ============================================================
   // reply byte selection by position
   always @*
   begin
      tb = 8'h00;
      case (pos_q)
         8'h00: tb = req_q[95:88]; // [R01] [R16]
         8'h01: tb = req_q[87:80];
         8'h02: tb = 8'h00; // [R02]
         8'h03: tb = 8'h00;
         8'h04: tb = 8'h00;
         8'h05: tb = rep_len[7:0]; // [R08] [R15]
         8'h06: tb = req_q[47:40]; // [R16]
         8'h07: tb = req_q[39:32];
         default:
         begin
            if (req_q[39:32] == `FC_READ)
            begin
               if (pos_q == 8'h08)
                  tb = last_q - `RD_FIXED_BYTES + 8'h01; // [R07]
               else
                  tb = data_q[pos_q[2:0] - 3'd1]; // [R09]
            end
            else
            begin
               case (pos_q)
                  8'h08: tb = req_q[31:24];
                  8'h09: tb = req_q[23:16];
                  8'h0a: tb = req_q[15:8];
                  default: tb = req_q[7:0]; // [R15]
               endcase
            end
         end
      endcase
   end
   // ============================================================
   // control: accept, gather packed bytes, send, then forward a write
   always @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_q <= ST_IDLE;
         req_q <= 96'h0;
         pos_q <= 8'h00;
         last_q <= 8'h00;
         rd_idx_q <= 6'h00;
         rd_cnt_q <= 4'h0;
         fill_q <= 3'd0;
         tx_vld_out <= 1'b0;
         tx_sof_out <= 1'b0;
         tx_eof_out <= 1'b0;
         tx_byte_out <= 8'h00;
         fwd_vld_out <= 1'b0;
         fwd_idx_out <= 6'h00;
         fwd_val_out <= 1'b0;
         busy_out <= 1'b0;
         for (i = 0; i < 8; i = i + 1)
            data_q[i] <= 8'h00;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               if (done && hdr_ok && (rd_ok || wr_ok))
               begin
                  req_q <= fr;
                  pos_q <= 8'h00;
                  busy_out <= 1'b1;
                  rd_idx_q <= f_addr[5:0] - 6'h00;
                  rd_cnt_q <= (f_arg > 16'h0008) ? 4'h8 : f_arg[3:0];
                  fill_q <= 3'd0;
                  if (rd_ok)
                  begin
                     last_q <= `RD_FIXED_BYTES + rd_bytes[7:0] - 8'h01; // [R07]
                     st_q <= ST_FETCH;
                  end
                  else
                  begin
                     last_q <= `WR_REPLY_BYTES - 8'h01;
                     st_q <= ST_SEND;
                  end
               end
            end
            ST_FETCH:
            begin
               // one byte per two cycles: set index, then take the registered byte
               if (rd_cnt_q == 4'h0)
               begin
                  st_q <= ST_SEND;
               end
               else if (pos_q[0] == 1'b0)
                  pos_q <= 8'h01;
               else
               begin
                  data_q[fill_q] <= pk_byte; // [R09] [R10]
                  fill_q <= fill_q + 3'd1;
                  pos_q <= 8'h00;
                  rd_idx_q <= rd_idx_q + 6'h08;
                  if ({5'h00, fill_q} + 8'h01 >= last_q - `RD_FIXED_BYTES + 8'h01)
                     rd_cnt_q <= 4'h0;
                  else
                     rd_cnt_q <= (req_q[15:0] - {10'h000, fill_q + 3'd1, 3'b000} > 16'h0008) ? 4'h8
                        : req_q[3:0] - {fill_q[0] + 1'b1, 3'b000};
               end
            end
            ST_SEND:
            begin
               if (tx_rdy_in || !tx_vld_out)
               begin
                  tx_vld_out <= 1'b1;
                  tx_byte_out <= tb;
                  tx_sof_out <= (pos_q == 8'h00);
                  tx_eof_out <= (pos_q == last_q);
                  if (pos_q == last_q)
                     st_q <= (req_q[39:32] == `FC_WRITE) ? ST_FWD : ST_IDLE;
                  pos_q <= pos_q + 8'h01;
                  if (pos_q == last_q && req_q[39:32] != `FC_WRITE)
                     busy_out <= 1'b0;
               end
            end
            ST_FWD:
            begin
               if (tx_rdy_in)
                  tx_vld_out <= 1'b0;
               // forward only once the last reply byte has been taken
               if (!tx_vld_out)
                  fwd_vld_out <= 1'b1; // [R14]
               fwd_idx_out <= req_q[21:16];
               fwd_val_out <= (req_q[15:0] == `VAL_ONE);
               if (fwd_vld_out && fwd_rdy_in)
               begin
                  fwd_vld_out <= 1'b0;
                  busy_out <= 1'b0;
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
         // a pending last byte may still be taken while fetching or idle
         if (st_q != ST_SEND && tx_rdy_in)
            tx_vld_out <= 1'b0;
      end
   end
endmodule

// file: bench/map_access_asserts.sv
// checker on the ports of the boolean point request handler
// assumes one clock, async active-low reset, attached by the bind below
`timescale 1ns/1ps
module map_access_asserts
(
   input wire core_clk_in, // clock
   input wire nrst_in, // reset
   input wire [7:0] unit_addr_in, // unit
   input wire rx_sof_in, // rx start
   input wire rx_vld_in, // rx valid
   input wire [7:0] rx_byte_in, // rx byte
   input wire tx_rdy_in, // tx ready
   input wire fwd_rdy_in, // fwd ready
   input wire tx_vld_out, // tx valid
   input wire tx_sof_out, // tx start
   input wire tx_eof_out, // tx end
   input wire [7:0] tx_byte_out, // tx byte
   input wire fwd_vld_out, // fwd valid
   input wire [5:0] fwd_idx_out, // fwd index
   input wire fwd_val_out, // fwd value
   input wire busy_out // busy
);
   // ============================================
   // reply byte position, advanced per taken byte
   reg [4:0] pos_q;
   always @(posedge core_clk_in or negedge nrst_in)
      if (!nrst_in)
         pos_q <= 5'h00;
      else if (tx_vld_out && tx_rdy_in)
         pos_q <= tx_eof_out ? 5'h00 : pos_q + 5'h01;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   a_reply_byte_stands: assert property (tx_vld_out && !tx_rdy_in |=> tx_vld_out && $stable(tx_byte_out))
      else $error("reply byte moved before taken");
   a_sof_first: assert property (tx_vld_out |-> tx_sof_out == (pos_q == 5'h00))
      else $error("start marker off first byte");
   a_proto_zero: assert property (tx_vld_out && pos_q inside {5'h02, 5'h03, 5'h04} |-> tx_byte_out == 8'h00)
      else $error("protocol tag or length high byte not zero");
   a_unit_echo: assert property (tx_vld_out && pos_q == 5'h06 |-> tx_byte_out == unit_addr_in)
      else $error("unit byte not echoed");
   a_func_echo: assert property (tx_vld_out && pos_q == 5'h07 |-> tx_byte_out inside {8'h01, 8'h05})
      else $error("function byte not served code");
   a_eof_length: assert property (tx_vld_out && tx_eof_out |-> pos_q >= 5'h09 && pos_q <= 5'h10)
      else $error("reply length out of range");
   a_fwd_held: assert property (fwd_vld_out && !fwd_rdy_in |=> fwd_vld_out && $stable({fwd_idx_out, fwd_val_out}))
      else $error("forward dropped before taken");
   a_fwd_after_reply: assert property ($rose(fwd_vld_out) |-> !tx_vld_out)
      else $error("forward raised during reply");
   // main scenarios seen
   c_write_reply: cover property (tx_vld_out && tx_rdy_in && tx_eof_out && pos_q == 5'h0b);
   c_fwd_taken: cover property (fwd_vld_out && fwd_rdy_in);
   c_tx_stall: cover property (tx_vld_out && !tx_rdy_in);
endmodule
bind tcp_boolean_map_access map_access_asserts chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
   .unit_addr_in(unit_addr_in), .rx_sof_in(rx_sof_in), .rx_vld_in(rx_vld_in), .rx_byte_in(rx_byte_in),
   .tx_rdy_in(tx_rdy_in), .fwd_rdy_in(fwd_rdy_in), .tx_vld_out(tx_vld_out), .tx_sof_out(tx_sof_out),
   .tx_eof_out(tx_eof_out), .tx_byte_out(tx_byte_out), .fwd_vld_out(fwd_vld_out),
   .fwd_idx_out(fwd_idx_out), .fwd_val_out(fwd_val_out), .busy_out(busy_out));

// file: bench/far_end_model.sv
// far side: reply sink and downstream forwarder, logging what it takes
// assumes the handler's valid/ready handshakes; slow_in halves the pace
`timescale 1ns/1ps
module far_end_model
(
   input wire core_clk_in, // clock
   input wire nrst_in, // reset
   input wire slow_in, // stall often
   input wire tx_vld_in, // tx valid
   input wire tx_sof_in, // tx start
   input wire tx_eof_in, // tx end
   input wire [7:0] tx_byte_in, // tx byte
   input wire fwd_vld_in, // fwd valid
   input wire [5:0] fwd_idx_in, // fwd index
   input wire fwd_val_in, // fwd value
   output reg tx_rdy_out, // tx taken
   output reg fwd_rdy_out // fwd taken
);
   // =======================================
   // capture log
   reg [7:0] buf_q [0:31];
   reg phase_q;
   reg [5:0] fidx_q;
   reg fval_q;
   integer len_q, replies_q, fwds_q;
   // readies alternate when slow so the handler must hold its offers
   always @(posedge core_clk_in or negedge nrst_in)
      if (!nrst_in)
      begin
         {tx_rdy_out, fwd_rdy_out, phase_q, fidx_q, fval_q} <= 10'h000;
         len_q <= 0;
         replies_q <= 0;
         fwds_q <= 0;
      end
      else
      begin
         phase_q <= ~phase_q;
         tx_rdy_out <= ~slow_in | phase_q;
         fwd_rdy_out <= ~slow_in | ~phase_q;
         if (tx_vld_in && tx_rdy_out)
         begin
            buf_q[tx_sof_in ? 0 : len_q] <= tx_byte_in;
            len_q <= tx_sof_in ? 1 : len_q + 1;
            replies_q <= replies_q + tx_eof_in;
         end
         if (fwd_vld_in && fwd_rdy_out)
         begin
            fidx_q <= fwd_idx_in;
            fval_q <= fwd_val_in;
            fwds_q <= fwds_q + 1;
         end
      end
endmodule

// file: bench/tb.sv
// testbench: sends request frames, judges replies and forwards
// assumes the handler, its bound checker and the far-side model
`timescale 1ns/1ps
module tb;
   reg core_clk_in = 1'b0;
   reg nrst_in = 1'b0;
   reg [7:0] unit_addr_in = 8'h01;
   reg rx_sof_in = 1'b0;
   reg rx_vld_in = 1'b0;
   reg [7:0] rx_byte_in = 8'h00;
   reg slow_in = 1'b0;
   wire tx_rdy_in, fwd_rdy_in, tx_vld_out, tx_sof_out, tx_eof_out, fwd_vld_out, fwd_val_out, busy_out;
   wire [7:0] tx_byte_out;
   wire [5:0] fwd_idx_out;
   integer bad_count = 0;
   integer checked = 0;
   integer cycles = 0;
   // ==============================
   // handler and far side
   tcp_boolean_map_access uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .unit_addr_in(unit_addr_in),
      .rx_sof_in(rx_sof_in), .rx_vld_in(rx_vld_in), .rx_byte_in(rx_byte_in), .tx_rdy_in(tx_rdy_in),
      .fwd_rdy_in(fwd_rdy_in), .tx_vld_out(tx_vld_out), .tx_sof_out(tx_sof_out), .tx_eof_out(tx_eof_out),
      .tx_byte_out(tx_byte_out), .fwd_vld_out(fwd_vld_out), .fwd_idx_out(fwd_idx_out),
      .fwd_val_out(fwd_val_out), .busy_out(busy_out));
   far_end_model far (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .slow_in(slow_in),
      .tx_vld_in(tx_vld_out), .tx_sof_in(tx_sof_out), .tx_eof_in(tx_eof_out), .tx_byte_in(tx_byte_out),
      .fwd_vld_in(fwd_vld_out), .fwd_idx_in(fwd_idx_out), .fwd_val_in(fwd_val_out),
      .tx_rdy_out(tx_rdy_in), .fwd_rdy_out(fwd_rdy_in));
   // 10 MHz clock
   always #50 core_clk_in = ~core_clk_in;
   // ==============================
   // shared helpers
   function [95:0] fr(input [15:0] t, p, l, input [7:0] u, c, input [15:0] a, v);
      fr = {t, p, l, u, c, a, v};
   endfunction
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp)
         begin
            bad_count = bad_count + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one request, wait out the service, then compare n reply bytes and nf forwards
   task req(input [95:0] f, input integer n, input [95:0] e, input integer nf);
      integer i, r0, f0;
      begin
         r0 = far.replies_q;
         f0 = far.fwds_q;
         for (i = 0; i < 12; i = i + 1)
         begin
            @(posedge core_clk_in);
            rx_vld_in <= 1'b1;
            rx_sof_in <= (i == 0);
            rx_byte_in <= f[95 - 8 * i -: 8];
         end
         @(posedge core_clk_in);
         rx_vld_in <= 1'b0;
         rx_sof_in <= 1'b0;
         repeat (3) @(posedge core_clk_in);
         // busy drops when the last read reply byte is offered, so also wait until it is taken
         for (i = 0; i < 400 && (busy_out !== 1'b0 || fwd_vld_out !== 1'b0 || tx_vld_out !== 1'b0); i = i + 1)
            @(posedge core_clk_in);
         chk(far.replies_q - r0, n != 0);
         chk(far.fwds_q - f0, nf);
         for (i = 0; i < n; i = i + 1)
            chk(far.buf_q[i], e[95 - 8 * i -: 8]);
      end
   endtask
   // ==============================
   // scenarios
   task t_write_set;
      begin
         @(posedge core_clk_in);
         unit_addr_in <= 8'hf7;
         req(fr(16'h1234, 16'h0000, 16'h0006, 8'hf7, 8'h05, 16'h0040, 16'hff00), 12,
            96'h1234_0000_0006_f705_0040_ff00, 1);
         chk({far.fidx_q, far.fval_q}, 16'h0001);
         unit_addr_in <= 8'h01;
      end
   endtask
   // sets 41 44 45 46 48 7f, sets then clears 43
   task t_pattern;
      reg [63:0] wa;
      reg [15:0] v;
      reg [95:0] f;
      integer i;
      begin
         wa = 64'h4144_4546_487f_4343;
         for (i = 0; i < 8; i = i + 1)
         begin
            v = (i == 7) ? 16'h0000 : 16'hff00;
            f = fr(16'h2000 + i[15:0], 16'h0000, 16'h0006, 8'h01, 8'h05, {8'h00, wa[63 - 8 * i -: 8]}, v);
            req(f, 12, f, 1);
            chk({far.fidx_q, far.fval_q}, {9'h000, wa[61 - 8 * i -: 6], v[15]});
         end
      end
   endtask
   // reads with a stalling sink; point 48 lies past the second window
   task t_read;
      begin
         @(posedge core_clk_in);
         slow_in <= 1'b1;
         req(fr(16'h3001, 16'h0000, 16'h0006, 8'h01, 8'h01, 16'h0040, 16'h000a), 11,
            {88'h3001_0000_0005_0101_0273_01, 8'h00}, 0);
         req(fr(16'h3002, 16'h0000, 16'h0006, 8'h01, 8'h01, 16'h0044, 16'h0004), 10,
            {80'h3002_0000_0004_0101_0107, 16'h0000}, 0);
         req(fr(16'h3003, 16'h0000, 16'h0006, 8'h01, 8'h01, 16'h007c, 16'h0004), 10,
            {80'h3003_0000_0004_0101_0108, 16'h0000}, 0);
         slow_in <= 1'b0;
      end
   endtask
   task t_refuse;
      reg [95:0] f;
      integer i;
      begin
         for (i = 0; i < 10; i = i + 1)
         begin
            case (i)
               0: f = fr(16'h4000, 16'h0001, 16'h0006, 8'h01, 8'h05, 16'h0041, 16'h0000);
               1: f = fr(16'h4001, 16'h0000, 16'h0005, 8'h01, 8'h05, 16'h0041, 16'h0000);
               2: f = fr(16'h4002, 16'h0000, 16'h0006, 8'h02, 8'h05, 16'h0041, 16'h0000);
               3: f = fr(16'h4003, 16'h0000, 16'h0006, 8'h01, 8'h03, 16'h0040, 16'h000a);
               4: f = fr(16'h4004, 16'h0000, 16'h0006, 8'h01, 8'h05, 16'h003f, 16'hff00);
               5: f = fr(16'h4005, 16'h0000, 16'h0006, 8'h01, 8'h05, 16'h0080, 16'h0000);
               6: f = fr(16'h4006, 16'h0000, 16'h0006, 8'h01, 8'h01, 16'h0040, 16'h0000);
               7: f = fr(16'h4007, 16'h0000, 16'h0006, 8'h01, 8'h01, 16'h007f, 16'h0002);
               8: f = fr(16'h4008, 16'h0000, 16'h0006, 8'h01, 8'h05, 16'h0041, 16'h1234);
               default: f = fr(16'h4009, 16'h0000, 16'h0006, 8'h01, 8'h01, 16'h003f, 16'h0002);
            endcase
            req(f, 0, 96'h0000_0000_0000_0000_0000_0000, 0);
         end
         unit_addr_in <= 8'hf8;
         req(fr(16'h4010, 16'h0000, 16'h0006, 8'hf8, 8'h05, 16'h0041, 16'h0000), 0,
            96'h0000_0000_0000_0000_0000_0000, 0);
         unit_addr_in <= 8'h01;
         req(fr(16'h4011, 16'h0000, 16'h0006, 8'h01, 8'h01, 16'h0040, 16'h000a), 11,
            {88'h4011_0000_0005_0101_0273_01, 8'h00}, 0);
      end
   endtask
   // ==============================
   // verdict and hang guard
   task test_done;
      begin
         $display("checked %0d bad_count %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   always @(posedge core_clk_in)
   begin
      cycles = cycles + 1;
      if (cycles == 6000)
      begin
         bad_count = bad_count + 1;
         test_done;
      end
   end
   initial
   begin
      repeat (3) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      t_write_set;
      t_pattern;
      t_read;
      t_refuse;
      test_done;
   end
endmodule
